// File: rtl/dbl_map.svh
/*
  Constants for the double-buffered converter host controller.
  Assumes inclusion by bare name from the rtl/ folder.
*/
`ifndef DBL_MAP_SVH
`define DBL_MAP_SVH

`define DBL_CODE_W          16
`define DBL_CODE_ZERO       16'h0000
`define DBL_CODE_POS_FULL   16'h7FFF
`define DBL_CODE_NEG_FULL   16'h8000
`define DBL_STEP_UV         305
`define DBL_CLK_NS          40
`define DBL_SETUP_NS        50
`define DBL_HOLD_NS         10
`define DBL_WP_NS           50
`define DBL_CLEAR_NS        200
`define DBL_CYC(ns)         (((ns) + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_SETUP_CYC       `DBL_CYC(`DBL_SETUP_NS)
`define DBL_HOLD_CYC        `DBL_CYC(`DBL_HOLD_NS)
`define DBL_CLEAR_CYC       `DBL_CYC(`DBL_CLEAR_NS)
`define DBL_WP_CYC          `DBL_CYC(`DBL_WP_NS)
`define DBL_CNT_W           4

`endif

// File: rtl/dbl_pkg.sv
/*
  Types for the double-buffered converter host controller.
  Assumes nothing of its surroundings.
*/
package dbl_pkg;
  typedef enum logic [2:0] {
    DBL_IDLE  = 3'b000,
    DBL_SETUP = 3'b001,
    DBL_PULSE = 3'b010,
    DBL_HOLD  = 3'b011,
    DBL_CLEAR = 3'b100
  } dbl_state_type;

  typedef enum logic [1:0] {
    DBL_OP_LOAD1  = 2'b00,
    DBL_OP_LOAD2  = 2'b01,
    DBL_OP_BOTH   = 2'b10,
    DBL_OP_ZERO   = 2'b11
  } dbl_op_type;
endpackage : dbl_pkg

// File: rtl/dbl_rst_sync.sv
/*
  Reset release synchroniser: asynchronous assert, two-flop release.
  Assumes arst_n is a raw active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dbl_rst_sync (
  input  wire logic core_clk,
  input  wire logic arst_n,
  output var  logic rst_n
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = 1'b1;
    sync_d = meta_q;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign rst_n = sync_q;
endmodule : dbl_rst_sync
`default_nettype wire

// File: rtl/dbl_host.sv
/*
  Host controller driving a 16-bit double-buffered converter through its
  parallel pins: data bus, write strobe, two latch enables and output zero.
  Assumes the converter pins are wired directly; commands come from logic
  on core_clk.
*/
// Operation
// - all controls are active low; host drives low to assert.
// - codes are twos complement; 7FFF max, 8000 min, 0000 zero.
// - host ties unused digital inputs to digital return.
// - multi-converter update: load first latches singly, then second together.
// - write strobe loads whichever latches have their own enable low.
// - transparent path: enables and strobe low, output zero high.
`timescale 1ns/1ps
`default_nettype none
`include "dbl_map.svh"
module dbl_host
  import dbl_pkg::*;
#(
  parameter int CONV_N = 1
) (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic                  cmd_valid,
  input  wire dbl_op_type            cmd_op,
  input  wire logic [`DBL_CODE_W-1:0] cmd_code,
  input  wire logic [CONV_N-1:0]     cmd_sel,
  output var  logic                  cmd_ready,
  output var  logic                  cmd_done,
  output var  logic [`DBL_CODE_W-1:0] data_out,
  output var  logic                  write_n,
  output var  logic [CONV_N-1:0]     stage_one_enable_n,
  output var  logic [CONV_N-1:0]     stage_two_enable_n,
  output var  logic                  output_zero_n,
  output var  logic [`DBL_CODE_W-1:0] shadow_code
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_n;

  dbl_rst_sync u_rst (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .rst_n    (rst_n)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [`DBL_CNT_W-1:0] cnt_of(input int cyc);
    cnt_of = (cyc < 1) ? `DBL_CNT_W'(1) : `DBL_CNT_W'(cyc);
  endfunction : cnt_of

  // true on the last cycle of a timed phase
  function automatic logic cnt_last(input logic [`DBL_CNT_W-1:0] cnt);
    cnt_last = (cnt <= `DBL_CNT_W'(1));
  endfunction : cnt_last

  // enables of the selected converters when the op reaches this latch
  function automatic logic [CONV_N-1:0] en_mask(
    input logic              hit,
    input logic [CONV_N-1:0] sel
  );
    en_mask = hit ? ~sel : '1;
  endfunction : en_mask

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  dbl_state_type           state_q,  state_d;
  logic [`DBL_CNT_W-1:0]   cnt_q,    cnt_d;
  logic [`DBL_CODE_W-1:0]  data_q,   data_d;
  logic                    wr_q,     wr_d;
  logic [CONV_N-1:0]       en1_q,    en1_d;
  logic [CONV_N-1:0]       en2_q,    en2_d;
  logic                    zero_q,   zero_d;
  logic                    ready_q,  ready_d;
  logic                    done_q,   done_d;
  logic [`DBL_CODE_W-1:0]  first_q,  first_d;
  logic [`DBL_CODE_W-1:0]  second_q, second_d;

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    data_d   = data_q;
    wr_d     = wr_q;
    en1_d    = en1_q;
    en2_d    = en2_q;
    zero_d   = zero_q;
    ready_d  = ready_q;
    done_d   = 1'b0;
    case (state_q)
      DBL_IDLE: begin
        if (cmd_valid && ready_q) begin
          ready_d = 1'b0;
          if (cmd_op == DBL_OP_ZERO) begin
            zero_d  = 1'b0;
            state_d = DBL_CLEAR;
            cnt_d   = cnt_of(`DBL_CLEAR_CYC);
          end else begin
            data_d  = cmd_code;
            en1_d   = en_mask(cmd_op != DBL_OP_LOAD2, cmd_sel);
            en2_d   = en_mask(cmd_op != DBL_OP_LOAD1, cmd_sel);
            state_d = DBL_SETUP;
            cnt_d   = cnt_of(`DBL_SETUP_CYC);
          end
        end
      end
      DBL_SETUP: begin
        wr_d    = 1'b0;
        state_d = DBL_PULSE;
        cnt_d   = cnt_of(`DBL_WP_CYC);
      end
      DBL_PULSE: begin
        if (!cnt_last(cnt_q)) begin
          cnt_d = cnt_q - `DBL_CNT_W'(1);
        end else begin
          wr_d    = 1'b1;
          state_d = DBL_HOLD;
          cnt_d   = cnt_of(`DBL_HOLD_CYC);
        end
      end
      DBL_HOLD: begin
        if (!cnt_last(cnt_q)) begin
          cnt_d = cnt_q - `DBL_CNT_W'(1);
        end else begin
          en1_d   = '1;
          en2_d   = '1;
          state_d = DBL_IDLE;
          ready_d = 1'b1;
          done_d  = 1'b1;
        end
      end
      DBL_CLEAR: begin
        if (!cnt_last(cnt_q)) begin
          cnt_d = cnt_q - `DBL_CNT_W'(1);
        end else begin
          zero_d   = 1'b1;
          state_d  = DBL_IDLE;
          ready_d  = 1'b1;
          done_d   = 1'b1;
        end
      end
      default: begin
        state_d = DBL_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= DBL_IDLE;
      cnt_q    <= '0;
      data_q   <= `DBL_CODE_ZERO;
      wr_q     <= 1'b1;
      en1_q    <= '1;
      en2_q    <= '1;
      zero_q   <= 1'b1;
      ready_q  <= 1'b1;
      done_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      data_q   <= data_d;
      wr_q     <= wr_d;
      en1_q    <= en1_d;
      en2_q    <= en2_d;
      zero_q   <= zero_d;
      ready_q  <= ready_d;
      done_q   <= done_d;
    end
  end

  // ------------------------------------------------------------
  // shadow of the converter latches
  // ------------------------------------------------------------
  // tracks what each latch holds once the strobe or the clear ends
  always_comb begin
    first_d  = first_q;
    second_d = second_q;
    if (state_q == DBL_PULSE && cnt_last(cnt_q)) begin
      if (en1_q != '1) begin
        first_d = data_q;
      end
      if (en2_q != '1) begin
        second_d = (en1_q != '1) ? data_q : first_q;
      end
    end else if (state_q == DBL_CLEAR && cnt_last(cnt_q)) begin
      first_d  = `DBL_CODE_ZERO;
      second_d = `DBL_CODE_ZERO;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_q  <= `DBL_CODE_ZERO;
      second_q <= `DBL_CODE_ZERO;
    end else begin
      first_q  <= first_d;
      second_q <= second_d;
    end
  end

  assign cmd_ready          = ready_q;
  assign cmd_done           = done_q;
  assign data_out           = data_q;
  assign write_n            = wr_q;
  assign stage_one_enable_n = en1_q;
  assign stage_two_enable_n = en2_q;
  assign output_zero_n      = zero_q;
  assign shadow_code        = second_q;
endmodule : dbl_host
`default_nettype wire

// File: sim/dbl_host_asserts.sv
/* pin checks for the converter host controller.
   assumes a bind onto dbl_host. */
`timescale 1ns/1ps
`default_nettype none
`include "dbl_map.svh"
module dbl_host_asserts
  import dbl_pkg::*;
#(
  parameter int CONV_N = 1
) (
  input wire logic                   core_clk,
  input wire logic                   arst_n,
  input wire logic                   cmd_valid,
  input wire dbl_op_type             cmd_op,
  input wire logic [`DBL_CODE_W-1:0] cmd_code,
  input wire logic [CONV_N-1:0]      cmd_sel,
  input wire logic                   cmd_ready,
  input wire logic                   cmd_done,
  input wire logic [`DBL_CODE_W-1:0] data_out,
  input wire logic                   write_n,
  input wire logic [CONV_N-1:0]      stage_one_enable_n,
  input wire logic [CONV_N-1:0]      stage_two_enable_n,
  input wire logic                   output_zero_n,
  input wire logic [`DBL_CODE_W-1:0] shadow_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wr_has_en_a: assert property (
    !write_n |-> !(&stage_one_enable_n) || !(&stage_two_enable_n))
    else $error("strobe with no enable");
  wr_data_a: assert property (
    !write_n |-> $stable(data_out) && $stable(stage_one_enable_n)
      && $stable(stage_two_enable_n))
    else $error("data moved under strobe");
  wr_width_a: assert property (
    $fell(write_n) |-> !write_n ##1 !write_n ##1 write_n)
    else $error("strobe width");
  zero_width_a: assert property (
    $fell(output_zero_n) |-> (!output_zero_n) [*5] ##1 output_zero_n)
    else $error("clear width");
  zero_no_wr_a: assert property (!output_zero_n |-> write_n)
    else $error("write during clear");
  take_done_a: assert property (
    cmd_valid && cmd_ready && cmd_op != DBL_OP_ZERO |=> !cmd_ready [*4] ##1 cmd_done)
    else $error("done timing");
  zero_done_a: assert property (
    cmd_valid && cmd_ready && cmd_op == DBL_OP_ZERO |=> !cmd_ready [*5] ##1 cmd_done)
    else $error("clear done timing");
  zero_shadow_a: assert property (
    $rose(output_zero_n) |-> shadow_code == `DBL_CODE_ZERO)
    else $error("shadow not cleared");
  wr_hold_a: assert property (
    $rose(write_n) |-> ($stable(data_out) && $stable(stage_one_enable_n)
      && $stable(stage_two_enable_n)) ##1 ((&stage_one_enable_n) && (&stage_two_enable_n)))
    else $error("hold after strobe");
  cover property ($rose(write_n));
  cover property ($rose(output_zero_n));
  cover property (cmd_done);
endmodule : dbl_host_asserts
`default_nettype wire

// File: sim/dbl_conv_model.sv
/* behavioural model of the double-latched converter.
   assumes pins wired straight from dbl_host. */
`timescale 1ns/1ps
`default_nettype none
module dbl_conv_model (
  input  wire logic        output_zero_n,
  input  wire logic        write_n,
  input  wire logic        stage_one_enable_n,
  input  wire logic        stage_two_enable_n,
  input  wire logic [15:0] data_in,
  output var  logic [15:0] first_q,
  output var  logic [15:0] conv_code,
  output var  int          out_uv
);
  localparam int STEP_UV = 305;
  logic [15:0] din;

  // undriven data bits read low
  always @* begin
    for (int i = 0; i < 16; i++) begin
      din[i] = (data_in[i] === 1'b1);
    end
  end

  always @* begin
    if (!output_zero_n) begin
      first_q = 16'h0000;
      conv_code = 16'h0000;
    end else begin
      if (!write_n && !stage_one_enable_n) first_q = din;
      if (!write_n && !stage_two_enable_n) conv_code = first_q;
    end
  end

  // output in microvolts, one step per code
  assign out_uv = $signed(conv_code) * STEP_UV;
endmodule : dbl_conv_model
`default_nettype wire

// File: sim/dbl_host_test.sv
/* self-checking bench for dbl_host with one converter model.
   assumes the rtl files are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("Error %0t got %h exp %h", $time, a, b); end end
module dbl_host_test;
  import dbl_pkg::*;
  logic core_clk, arst_n, cmd_valid, cmd_ready, cmd_done, wr_n, oz_n, e1n, e2n;
  dbl_op_type cmd_op;
  logic [15:0] cmd_code, data_out, shadow, first_q, conv_code, e1, e2;
  logic [15:0] codes [3] = '{16'h7FFF, 16'h8000, 16'h0000};
  int out_uv;
  int mismatches = 0;
  int n_compared = 0;
  dbl_host #(.CONV_N(1)) dut_u (.core_clk(core_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_code(cmd_code), .cmd_sel(1'b1), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .data_out(data_out), .write_n(wr_n), .stage_one_enable_n(e1n),
    .stage_two_enable_n(e2n), .output_zero_n(oz_n), .shadow_code(shadow));
  dbl_conv_model conv_u (.output_zero_n(oz_n), .write_n(wr_n), .stage_one_enable_n(e1n),
    .stage_two_enable_n(e2n), .data_in(data_out), .first_q(first_q), .conv_code(conv_code),
    .out_uv(out_uv));
  function automatic void expect_op(dbl_op_type op, logic [15:0] c);
    case (op)
      DBL_OP_LOAD1: e1 = c;
      DBL_OP_LOAD2: e2 = e1;
      DBL_OP_BOTH: begin e1 = c; e2 = c; end
      default: begin e1 = 16'h0000; e2 = 16'h0000; end
    endcase
  endfunction : expect_op
  function automatic int uv_of(logic [15:0] c);
    return $signed(c) * 305;
  endfunction : uv_of
  task automatic check_idle;
    @(negedge core_clk);
    `CHK(wr_n, 1'b1)
    `CHK(oz_n, 1'b1)
    `CHK({e1n, e2n}, 2'b11)
    `CHK(cmd_ready, 1'b1)
    `CHK(cmd_done, 1'b0)
    `CHK(data_out, 16'h0000)
    `CHK(shadow, 16'h0000)
  endtask : check_idle
  task automatic run(input dbl_op_type op, input logic [15:0] c);
    int n;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_code <= c;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin @(negedge core_clk); n++; end while (cmd_done !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    expect_op(op, c);
    `CHK(first_q, e1)
    `CHK(conv_code, e2)
    `CHK(shadow, e2)
    `CHK(out_uv, uv_of(e2))
  endtask : run
  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #80000;
    mismatches++;
    end_of_test;
  end
  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = DBL_OP_LOAD1;
    cmd_code = 16'h0000;
    e1 = 16'h0000;
    e2 = 16'h0000;
    void'($urandom(32'h8B9E032B));
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check_idle;
    foreach (codes[i]) run(DBL_OP_BOTH, codes[i]);
    run(DBL_OP_LOAD1, 16'h4000);
    run(DBL_OP_LOAD2, 16'hFFFF);
    run(DBL_OP_ZERO, 16'h1234);
    run(DBL_OP_LOAD2, 16'h5555);
    // reset in the middle of a strobe, then resynchronise both latches
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= DBL_OP_BOTH;
    cmd_code <= 16'h2AAA;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b0;
    check_idle;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    check_idle;
    run(DBL_OP_BOTH, 16'h1357);
    repeat (12) run(dbl_op_type'($urandom % 4), 16'($urandom));
    end_of_test;
  end
endmodule : dbl_host_test
bind dbl_host dbl_host_asserts #(.CONV_N(CONV_N)) chk_u (.core_clk(core_clk), .arst_n(arst_n),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_code(cmd_code), .cmd_sel(cmd_sel),
  .cmd_ready(cmd_ready), .cmd_done(cmd_done), .data_out(data_out), .write_n(write_n),
  .stage_one_enable_n(stage_one_enable_n), .stage_two_enable_n(stage_two_enable_n),
  .output_zero_n(output_zero_n), .shadow_code(shadow_code));
`default_nettype wire
